// >>> rtl/tmss_defs.svh
// Constants for the touch matrix scan sequencer
`ifndef TMSS_DEFS_SVH
`define TMSS_DEFS_SVH
// Overview of operation
// - Each scan starts at row 0, column 0; one key at a time.
// - Row index advances fastest; all rows of a column, then next column.
// - Each key gets a burst of 0 to 64 samples from its length.
// - A key's burst finishes before the next key is sampled.
// - After the last pulse the analog level is converted to digital.
// - One row line pulses once per sample; other rows stay idle.
// - The matrix is always 8 rows by 8 columns.
// - Zero-length key gives no pulses but still uses its time slot.
// - Reduced variants disable keys from 32 or 48 upward; by default (KEY_LIMIT 64) none are disabled.
// - Column is shown as a 3-bit code for the whole burst.
// - Eight active-high column gates; only the selected one asserted.
// - Sampling window from row rise to capture end is fixed 167 ns; the code holds WINDOW for 17 cycles (170 ns).
// - Columns grounded after window ends and before row falls.
// - Both cancel outputs high when idle; low steps subtract charge.
// - At burst end the key's offset drives the row lines (R2R).
// - Analog input sampled 8 us after offset is applied.
// - Integrator is reset between bursts.
// - Conversion result per key is 8 bits.

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TMSS_CLK_PERIOD_PS    10000
`define TMSS_WINDOW_PS       167000
`define TMSS_SETTLE_PS      8000000
`define TMSS_WINDOW_CYC  (`TMSS_WINDOW_PS / `TMSS_CLK_PERIOD_PS)
`define TMSS_SETTLE_CYC  ((`TMSS_SETTLE_PS + `TMSS_CLK_PERIOD_PS - 1) / `TMSS_CLK_PERIOD_PS)
`define TMSS_PRETRIG_CYC      1
`define TMSS_GROUND_CYC       1
`define TMSS_GAP_CYC          2
`define TMSS_RESET_CYC        4
// ----------------------------------------------------------------------
// Sizes and defaults
// ----------------------------------------------------------------------
`define TMSS_ROWS             8
`define TMSS_COLS             8
`define TMSS_KEYS            64
`define TMSS_BURST_MAX       64
`define TMSS_CANCEL_IDLE   2'h3
`endif

// >>> rtl/tmss_pkg.sv
// Types shared by the scan sequencer modules
package tmss_pkg;
  typedef enum logic [7:0] {
    TMSS_IDLE   = 8'h01,
    TMSS_RESET  = 8'h02,
    TMSS_TRIG   = 8'h04,
    TMSS_WINDOW = 8'h08,
    TMSS_GROUND = 8'h10,
    TMSS_GAP    = 8'h20,
    TMSS_SETTLE = 8'h40,
    TMSS_CONV   = 8'h80
  } tmss_state_t;
  typedef logic [5:0] tmss_key_t;
endpackage : tmss_pkg

// >>> rtl/tmss_pulse_if.sv
// Handshake between the sequencer and its phase timer
`timescale 1ns/100ps
`default_nettype none
interface tmss_pulse_if;
  logic        start;
  logic [15:0] count;
  logic        done;
  modport ctl (output start, output count, input done);
  modport tmr (input start, input count, output done);
endinterface : tmss_pulse_if
`default_nettype wire

// >>> rtl/tmss_timer.sv
// Down counter that times each phase of the sequencer
`timescale 1ns/100ps
`default_nettype none
module tmss_timer (
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  sys_rst,
  // Phase request
  tmss_pulse_if.tmr  tp
);
  logic [15:0] cnt_q;
  logic        run_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
    end else if (tp.start) begin
      cnt_q <= tp.count;
      run_q <= 1'b1;
    end else if (run_q) begin
      if (cnt_q <= 16'h0001) begin
        run_q <= 1'b0;
      end
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  // Done in the last cycle of the phase
  assign tp.done = run_q && (cnt_q <= 16'h0001) && !tp.start;
endmodule : tmss_timer
`default_nettype wire

// >>> rtl/tmss_sequencer.sv
// Key-by-key burst, offset and conversion sequencer for an 8x8 matrix
`timescale 1ns/100ps
`default_nettype none
`include "tmss_defs.svh"
module tmss_sequencer #(
  parameter int KEY_LIMIT = `TMSS_KEYS,
  parameter int SETTLE_CYC = `TMSS_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Control
  input  wire logic        scan_start,
  output logic             scan_busy,
  // Per-key setup lookup, indexed by current key
  output logic [5:0]       key_index,
  input  wire logic [6:0]  burst_length,
  input  wire logic [7:0]  key_offset,
  input  wire logic [1:0]  cancel_pattern,
  // Matrix drive
  output logic [7:0]       row_drive,
  output logic [2:0]       mux_column_select,
  output logic [7:0]       column_gate_drive,
  output logic             gate_trigger,
  output logic [1:0]       cancel_capacitor,
  output logic             integrator_reset,
  // Converter
  output logic             adc_sample,
  input  wire logic [7:0]  adc_data,
  input  wire logic        adc_done,
  output logic [7:0]       result_data,
  output logic [5:0]       result_key,
  output logic             result_valid
);
  // ----------------------------------------------------------------------
  // State and counters
  // ----------------------------------------------------------------------
  tmss_pkg::tmss_state_t state_q;
  tmss_pkg::tmss_key_t   key_q;
  logic [6:0]            pulse_q;
  logic [6:0]            len_q;
  logic                  start_q;
  logic [15:0]           count_d;
  logic                  enabled;
  logic                  last_key;

  // ----------------------------------------------------------------------
  // Phase timer
  // ----------------------------------------------------------------------
  // Each phase runs its count plus one cycle, start cycle included
  tmss_pulse_if tp ();

  tmss_timer u_timer (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tp      (tp)
  );

  // ----------------------------------------------------------------------
  // Key decode
  // ----------------------------------------------------------------------
  // keys at or above the variant limit are never sampled
  assign enabled   = (32'(key_q) < KEY_LIMIT);
  assign last_key  = (key_q == 6'h3F);
  assign key_index = key_q;
  assign scan_busy = (state_q != tmss_pkg::TMSS_IDLE);

  // ----------------------------------------------------------------------
  // Phase timing
  // ----------------------------------------------------------------------
  always_comb begin
    count_d = 16'h0001;
    case (state_q)
      tmss_pkg::TMSS_RESET:  count_d = 16'(`TMSS_RESET_CYC);
      tmss_pkg::TMSS_TRIG:   count_d = 16'(`TMSS_PRETRIG_CYC);
      tmss_pkg::TMSS_WINDOW: count_d = 16'(`TMSS_WINDOW_CYC);
      tmss_pkg::TMSS_GROUND: count_d = 16'(`TMSS_GROUND_CYC);
      tmss_pkg::TMSS_GAP:    count_d = 16'(`TMSS_GAP_CYC);
      tmss_pkg::TMSS_SETTLE: count_d = 16'(SETTLE_CYC);
      default:               count_d = 16'h0001;
    endcase
  end
  assign tp.start = start_q;
  assign tp.count = count_d;

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= tmss_pkg::TMSS_IDLE;
      key_q   <= 6'h00;
      pulse_q <= 7'h00;
      len_q   <= 7'h00;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (state_q)
        tmss_pkg::TMSS_IDLE: begin
          if (scan_start) begin
            key_q   <= 6'h00;
            state_q <= tmss_pkg::TMSS_RESET;
            start_q <= 1'b1;
          end
        end
        tmss_pkg::TMSS_RESET: begin
          if (tp.done) begin
            // disabled keys run empty whatever their setting
            // others clamp to the burst maximum
            if (!enabled) begin
              len_q <= 7'h00;
            end else if (burst_length > 7'(`TMSS_BURST_MAX)) begin
              len_q <= 7'(`TMSS_BURST_MAX);
            end else begin
              len_q <= burst_length;
            end
            pulse_q <= 7'h00;
            state_q <= tmss_pkg::TMSS_TRIG;
            start_q <= 1'b1;
          end
        end
        tmss_pkg::TMSS_TRIG: begin
          if (tp.done) begin
            state_q <= tmss_pkg::TMSS_WINDOW;
            start_q <= 1'b1;
          end
        end
        tmss_pkg::TMSS_WINDOW: begin
          if (tp.done) begin
            state_q <= tmss_pkg::TMSS_GROUND;
            start_q <= 1'b1;
          end
        end
        tmss_pkg::TMSS_GROUND: begin
          if (tp.done) begin
            state_q <= tmss_pkg::TMSS_GAP;
            pulse_q <= pulse_q + 7'h01;
            start_q <= 1'b1;
          end
        end
        tmss_pkg::TMSS_GAP: begin
          // whole burst before moving on
          // Zero-length key still spends one empty sample period
          if (tp.done) begin
            if (pulse_q < 7'(`TMSS_BURST_MAX) && pulse_q < len_q) begin
              state_q <= tmss_pkg::TMSS_TRIG;
            end else begin
              state_q <= tmss_pkg::TMSS_SETTLE;
            end
            start_q <= 1'b1;
          end
        end
        tmss_pkg::TMSS_SETTLE: begin
          if (tp.done) begin
            state_q <= tmss_pkg::TMSS_CONV;
          end
        end
        tmss_pkg::TMSS_CONV: begin
          if (adc_done) begin
            if (last_key) begin
              state_q <= tmss_pkg::TMSS_IDLE;
            end else begin
              // row index in the low bits advances fastest
              key_q   <= key_q + 6'h01;
              state_q <= tmss_pkg::TMSS_RESET;
              start_q <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= tmss_pkg::TMSS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Drives
  // ----------------------------------------------------------------------
  // key = column*8 + row
  // Rows double as the offset ladder once the burst is over
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      row_drive <= 8'h00;
    end else begin
      case (state_q)
        // zero-length keys skip pulses but keep their slot
        tmss_pkg::TMSS_TRIG: begin
          row_drive <= 8'h00;
          if (tp.done && pulse_q < len_q) begin
            row_drive <= 8'h01 << key_q[2:0];
          end
        end
        tmss_pkg::TMSS_WINDOW, tmss_pkg::TMSS_GROUND: begin
          if (!(state_q == tmss_pkg::TMSS_GROUND && tp.done)) begin
            row_drive <= row_drive;
          end else begin
            row_drive <= 8'h00;
          end
        end
        // offset on the row lines after the burst
        tmss_pkg::TMSS_SETTLE, tmss_pkg::TMSS_CONV: begin
          row_drive <= key_offset;
        end
        tmss_pkg::TMSS_GAP: begin
          row_drive <= (tp.done && pulse_q >= len_q) ? key_offset : 8'h00;
        end
        default: begin
          row_drive <= 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Column select and gates
  // ----------------------------------------------------------------------
  // Registered, so the gates trail the state by one cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mux_column_select <= 3'h0;
      column_gate_drive <= 8'h00;
    end else begin
      // column code held through the burst
      mux_column_select <= key_q[5:3];
      // only the selected column gate high while sampling
      if ((state_q == tmss_pkg::TMSS_TRIG ||
           state_q == tmss_pkg::TMSS_WINDOW) && len_q != 7'h00) begin
        column_gate_drive <= 8'h01 << key_q[5:3];
      end else begin
        column_gate_drive <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Gate trigger
  // ----------------------------------------------------------------------
  // One cycle wide; the row rises on the edge after it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gate_trigger <= 1'b0;
    end else begin
      // trigger raised ahead of the row pulse
      gate_trigger <= (state_q == tmss_pkg::TMSS_TRIG) &&
                      (pulse_q < len_q) && !tp.done;
    end
  end

  // ----------------------------------------------------------------------
  // Charge cancel and integrator reset
  // ----------------------------------------------------------------------
  // Pattern is taken every cycle; keep it stable through a burst
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cancel_capacitor <= `TMSS_CANCEL_IDLE;
      integrator_reset <= 1'b0;
    end else begin
      // cancel lines high unless stepped inside a burst
      if (state_q == tmss_pkg::TMSS_TRIG || state_q == tmss_pkg::TMSS_WINDOW
          || state_q == tmss_pkg::TMSS_GROUND
          || state_q == tmss_pkg::TMSS_GAP) begin
        cancel_capacitor <= ~cancel_pattern;
      end else begin
        cancel_capacitor <= `TMSS_CANCEL_IDLE;
      end
      integrator_reset <= (state_q == tmss_pkg::TMSS_RESET);
    end
  end

  // ----------------------------------------------------------------------
  // Conversion result
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      adc_sample   <= 1'b0;
      result_data  <= 8'h00;
      result_key   <= 6'h00;
      result_valid <= 1'b0;
    end else begin
      // Result stands until the next key converts
      // sample strobe at end of settle
      adc_sample   <= (state_q == tmss_pkg::TMSS_SETTLE) && tp.done;
      result_valid <= 1'b0;
      if (state_q == tmss_pkg::TMSS_CONV && adc_done) begin
        result_data  <= adc_data;
        result_key   <= key_q;
        result_valid <= 1'b1;
      end
    end
  end
endmodule : tmss_sequencer
`default_nettype wire

// >>> bench/tmss_seq_checker.sv
// Port checker for the scan sequencer
`timescale 1ns/100ps
`default_nettype none
module tmss_seq_checker #(
  parameter int KEY_LIMIT = 64
) (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       sys_rst,
  // Control and lookup
  input wire logic       scan_start,
  input wire logic       scan_busy,
  input wire logic [5:0] key_index,
  input wire logic [6:0] burst_length,
  // Matrix drive
  input wire logic [7:0] row_drive,
  input wire logic [2:0] mux_column_select,
  input wire logic [7:0] column_gate_drive,
  input wire logic       gate_trigger,
  input wire logic [1:0] cancel_capacitor,
  input wire logic       integrator_reset,
  // Converter
  input wire logic       adc_sample,
  input wire logic [7:0] adc_data,
  input wire logic       adc_done,
  input wire logic [7:0] result_data,
  input wire logic       result_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [4:0] gate_q;
  logic [6:0] pulse_q;
  logic [6:0] want_len;
  // Keys past the limit run empty; long settings clamp
  assign want_len = (key_index >= KEY_LIMIT) ? 7'h00 :
                    (burst_length > 7'h40) ? 7'h40 : burst_length;
  always_ff @(posedge mclk) begin
    if (sys_rst || !(|column_gate_drive)) gate_q <= 5'h00;
    else gate_q <= gate_q + 5'h01;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst || integrator_reset) pulse_q <= 7'h00;
    else if (gate_trigger && |column_gate_drive) pulse_q <= pulse_q + 7'h01;
  end
  AST_CANCEL_IDLE: assert property (
    !scan_busy |-> cancel_capacitor == 2'h3) else $error("cancel not idle");
  AST_START: assert property (
    !scan_busy && scan_start |=> scan_busy) else $error("scan not started");
  AST_COL_ONEHOT: assert property (
    |column_gate_drive |-> column_gate_drive == 8'h01 << mux_column_select)
    else $error("column gate not selected column");
  AST_MUX_SEL: assert property (
    gate_trigger |-> mux_column_select == key_index[5:3])
    else $error("mux select wrong");
  AST_ROW_RISE: assert property (
    gate_trigger && |column_gate_drive |=>
    row_drive == 8'h01 << key_index[2:0]) else $error("row pulse wrong");
  AST_WINDOW: assert property (
    $fell(|column_gate_drive) |-> gate_q == 5'h13)
    else $error("sample window length wrong");
  AST_GROUND: assert property (
    $fell(|row_drive) |-> $past(column_gate_drive) == 8'h00)
    else $error("row fell with column open");
  AST_BURST: assert property (
    adc_sample |-> pulse_q == want_len) else $error("burst count wrong");
  AST_SETTLE: assert property (
    adc_sample |-> row_drive == $past(row_drive, 8))
    else $error("offset moved during settle");
  AST_RESULT: assert property (
    adc_done |=> result_valid && result_data == $past(adc_data))
    else $error("result not taken");
  AST_INTEG: assert property (
    $rose(integrator_reset) |-> integrator_reset [*5] ##1 !integrator_reset)
    else $error("integrator reset length wrong");
  cover property (adc_sample && pulse_q == 7'h40);
  cover property (adc_sample && want_len == 7'h00);
  cover property (scan_start && scan_busy);
endmodule : tmss_seq_checker
`default_nettype wire

// >>> bench/tmss_analog_model.sv
// Clamp, mux, integrator and converter model
`timescale 1ns/100ps
`default_nettype none
module tmss_analog_model (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  // Matrix side
  input wire logic [7:0]  row_drive,
  input wire logic [2:0]  mux_column_select,
  input wire logic [7:0]  column_gate_drive,
  input wire logic        gate_trigger,
  input wire logic        integrator_reset,
  // Converter
  input wire logic        adc_sample,
  output var logic [7:0]  adc_data = 8'hA5,
  output var logic        adc_done = 1'b0
);
  logic [7:0] charge_q;
  logic [7:0] held_q;
  logic [1:0] wait_q;
  logic       armed_q;
  // mux opens only after a trigger
  always @(posedge mclk) armed_q <= gate_trigger && |column_gate_drive;
  always @(posedge mclk) begin
    if (sys_rst || integrator_reset) charge_q <= 8'h00;
    else if (armed_q && |row_drive &&
             column_gate_drive == 8'h01 << mux_column_select)
      charge_q <= charge_q + 8'h01;
  end
  // Settled level taken at sample; data toggles otherwise
  always @(posedge mclk) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (sys_rst) wait_q <= 2'h0;
    else if (adc_sample) begin
      held_q <= charge_q + row_drive;
      wait_q <= 2'h3;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
      if (wait_q == 2'h1) begin
        adc_done <= 1'b1;
        adc_data <= held_q;
      end
    end
  end
endmodule : tmss_analog_model
`default_nettype wire

// >>> bench/touch_matrix_scan_sequencer_tb.sv
// Testbench for the scan sequencer
`timescale 1ns/100ps
`default_nettype none
module touch_matrix_scan_sequencer_tb;
  typedef struct packed {logic [6:0] len; logic [7:0] off; logic [7:0] want;}
    tmss_row_t;
  localparam int KEY_LIMIT = 48;
  logic mclk = 1'b0, sys_rst = 1'b1, scan_start = 1'b0;
  logic [6:0] burst_length = 7'h00;
  logic [7:0] key_offset = 8'h00, row_drive, column_gate_drive, adc_data;
  logic [7:0] result_data;
  logic [1:0] cancel_pattern = 2'h0, cancel_capacitor;
  logic [5:0] key_index, result_key;
  logic [2:0] mux_column_select;
  logic scan_busy, gate_trigger, integrator_reset, adc_sample, adc_done;
  logic result_valid;
  int err_total = 0, samples_checked = 0;
  tmss_row_t rows [64];
  always #5 mclk = ~mclk;
  tmss_sequencer #(.KEY_LIMIT(KEY_LIMIT), .SETTLE_CYC(10)) tmss_sequencer_i (
    .mclk(mclk), .sys_rst(sys_rst), .scan_start(scan_start),
    .scan_busy(scan_busy), .key_index(key_index),
    .burst_length(burst_length), .key_offset(key_offset),
    .cancel_pattern(cancel_pattern), .row_drive(row_drive),
    .mux_column_select(mux_column_select),
    .column_gate_drive(column_gate_drive), .gate_trigger(gate_trigger),
    .cancel_capacitor(cancel_capacitor),
    .integrator_reset(integrator_reset), .adc_sample(adc_sample),
    .adc_data(adc_data), .adc_done(adc_done), .result_data(result_data),
    .result_key(result_key), .result_valid(result_valid));
  tmss_analog_model tmss_analog_model_i (
    .mclk(mclk), .sys_rst(sys_rst), .row_drive(row_drive),
    .mux_column_select(mux_column_select),
    .column_gate_drive(column_gate_drive), .gate_trigger(gate_trigger),
    .integrator_reset(integrator_reset), .adc_sample(adc_sample),
    .adc_data(adc_data), .adc_done(adc_done));
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic wait_res;
    int t;
    t = 0;
    @(negedge mclk);
    while (result_valid !== 1'b1 && t < 3000) begin
      @(negedge mclk);
      t++;
    end
    if (t >= 3000) err_total++;
  endtask : wait_res
  task automatic pulse_start;
    @(negedge mclk) scan_start <= 1'b1;
    @(negedge mclk) scan_start <= 1'b0;
  endtask : pulse_start
  task automatic idle_checks;
    check("busy", {7'h00, scan_busy}, 8'h00);
    check("rows", row_drive, 8'h00);
    check("cancel", {6'h00, cancel_capacitor}, 8'h03);
  endtask : idle_checks
  // Full scan; poke gives a start that must be ignored
  task automatic run_scan(input bit poke);
    pulse_start();
    for (int n = 0; n < 64; n++) begin
      wait_res();
      check("key", {2'h0, result_key}, n[7:0]);
      check("data", result_data, rows[n].want);
      if (poke && n == 5) pulse_start();
    end
    repeat (40) @(negedge mclk);
    check("busy end", {7'h00, scan_busy}, 8'h00);
  endtask : run_scan
  // Setup lookup answers the current key
  always @(negedge mclk) begin
    burst_length <= rows[key_index].len;
    key_offset <= rows[key_index].off;
    cancel_pattern <= key_index[1:0];
    if (gate_trigger === 1'b1)
      check("cancel", {6'h00, cancel_capacitor}, {6'h00, ~cancel_pattern});
  end
  initial begin
    #600000;
    err_total++;
    wrap_up();
  end
  initial begin
    for (int k = 0; k < 64; k++) begin
      // key 1 disabled by zero length
      rows[k].len = (k == 1) ? 7'h00 : (k == 2) ? 7'h40 :
                    (k == 3) ? 7'h64 : 7'(k % 3 + 1);
      rows[k].off = 8'(k * 3);
      rows[k].want = rows[k].off + ((k >= KEY_LIMIT) ? 8'h00 :
                     (rows[k].len > 7'h40) ? 8'h40 : {1'b0, rows[k].len});
    end
    repeat (4) @(negedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    idle_checks();
    run_scan(1'b1);
    pulse_start();
    wait_res();
    wait_res();
    sys_rst <= 1'b1;
    repeat (4) @(negedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    idle_checks();
    run_scan(1'b0);
    wrap_up();
  end
endmodule : touch_matrix_scan_sequencer_tb
bind tmss_sequencer tmss_seq_checker #(.KEY_LIMIT(KEY_LIMIT)) tmss_seq_checker_i (
  .mclk(mclk), .sys_rst(sys_rst), .scan_start(scan_start),
  .scan_busy(scan_busy), .key_index(key_index),
  .burst_length(burst_length), .row_drive(row_drive),
  .mux_column_select(mux_column_select),
  .column_gate_drive(column_gate_drive), .gate_trigger(gate_trigger),
  .cancel_capacitor(cancel_capacitor), .integrator_reset(integrator_reset),
  .adc_sample(adc_sample), .adc_data(adc_data), .adc_done(adc_done),
  .result_data(result_data), .result_valid(result_valid));
`default_nettype wire
